// ===== inc/bpp_map.vh
// Register offsets, field positions and reset values of the port block.
`ifndef BPP_MAP_VH
`define BPP_MAP_VH
`define BPP_OFS_PIN_DATA 4'h0
`define BPP_OFS_DIRECTION 4'h1
`define BPP_OFS_OUT_LATCH 4'h2
`define BPP_OFS_ANALOG_SEL 4'h3
`define BPP_OFS_FUNC_ENABLE 4'h4
`define BPP_RST_DIRECTION 8'hFF
`define BPP_RST_OUT_LATCH 8'h00
`define BPP_RST_ANALOG_SEL 8'h3F
`define BPP_ANALOG_MASK 8'h3F
`define BPP_RST_FUNC_ENABLE 8'h00
`define BPP_FE_DEBUG 0
`define BPP_FE_LCD 1
`define BPP_FE_ANALOG 2
`define BPP_FE_BIAS 3
`define BPP_FE_EXTINT 4
`define BPP_FE_CHANGE 5
`endif

// ===== rtl/bpp_port.v
// Eight-pin bidirectional port with Avalon-MM registers and output priority.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "bpp_map.vh"
// Register map, one byte per word: 0 pin data, 1 direction,
// 2 output latch, 3 analog select, 4 function enable.
// Function enable bits: 0 debug, 1 LCD, 2 analog, 3 bias,
// 4 external interrupt, 5 change sense.
module bpp_port
(
	input wire core_clk, // System clock, 100 MHz.
	input wire sys_rst, // Synchronous reset, active high.
	input wire [3:0] avs_address, // Register word address.
	input wire avs_read, // Read request.
	input wire avs_write, // Write request.
	input wire [31:0] avs_writedata, // Write data.
	input wire [3:0] avs_byteenable, // Byte enables.
	output wire avs_waitrequest, // Stall until answer is ready.
	output reg [31:0] avs_readdata, // Read data.
	input wire [7:0] pinIn, // Pin levels from the pads.
	output wire [7:0] pinOut, // Pin output level.
	output wire [7:0] pinOe, // Pin output enable, high drives.
	input wire [7:0] lcdOutEn, // Segment/common drive enables.
	input wire [7:0] lcdOutVal, // Segment/common drive levels.
	input wire [7:0] biasOutEn, // Bias level enables, pins 1 to 3.
	input wire [7:0] biasOutVal, // Bias level drive values.
	input wire extIntOutEn, // External interrupt override on pin 0.
	input wire extIntOutVal, // External interrupt override level.
	input wire [7:0] changeOutEn, // Change-sense override enables.
	input wire [7:0] changeOutVal, // Change-sense override levels.
	input wire [1:0] debugOutEn, // Debug clock/data drive enables.
	input wire [1:0] debugOutVal, // Debug clock/data drive levels.
	output reg [7:0] digitalIn, // Synchronised digital pin levels.
	output reg [7:0] changeSenseIn, // Synchronised levels, analog-selected pins read low.
	output wire [7:0] analogEnable // Pin handed to the analog input.
);
	// Software-visible registers.
	reg [7:0] pinDirection_q;
	reg [7:0] outLatch_q;
	reg [7:0] analogSel_q;
	reg [5:0] funcEnable_q;

	// Pad synchroniser stages and the agreed pin level.
	reg [7:0] sync1_q;
	reg [7:0] sync2_q;
	reg [7:0] sync3_q;
	reg [7:0] pinLevel_q;

	// Bus handshake, register selects and read words.
	reg ack_q;
	wire access;
	wire [7:0] wrByte;
	wire [7:0] rmwValue;
	wire [7:0] readPins;
	reg [31:0] readMux;
	wire selData;
	wire selDir;
	wire selLatch;
	wire selAna;
	wire selFunc;
	wire wrTake;
	wire wrLane0;
	wire rdTake;
	wire [31:0] rdPinData;
	wire [31:0] rdDirection;
	wire [31:0] rdLatch;
	wire [31:0] rdAnalog;
	wire [31:0] rdFunc;

	// Owner codes of the pin output multiplexer, highest first.
	localparam OWN_DEBUG = 3'b000;
	localparam OWN_LCD = 3'b001;
	localparam OWN_ANALOG = 3'b010;
	localparam OWN_BIAS = 3'b011;
	localparam OWN_EXTINT = 3'b100;
	localparam OWN_CHANGE = 3'b101;
	localparam OWN_LATCH = 3'b110;

	assign access = (avs_read | avs_write) & ~ack_q;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wrByte = avs_writedata[7:0];
	// Digital reads of analog pins are forced low.
	assign readPins = pinLevel_q & ~analogSel_q;
	// Unwritten lanes keep the sampled pin value, so the whole byte lands.
	assign rmwValue = avs_byteenable[0] ? wrByte : readPins;
	assign analogEnable = analogSel_q & {8{funcEnable_q[`BPP_FE_ANALOG]}};

	// Register selects, used by the write paths only; the read mux decodes avs_address itself.
	assign selData = (avs_address == `BPP_OFS_PIN_DATA);
	assign selDir = (avs_address == `BPP_OFS_DIRECTION);
	assign selLatch = (avs_address == `BPP_OFS_OUT_LATCH);
	assign selAna = (avs_address == `BPP_OFS_ANALOG_SEL);
	assign selFunc = (avs_address == `BPP_OFS_FUNC_ENABLE);
	// A write lands on the edge where waitrequest is low.
	assign wrTake = avs_write & ack_q;
	// Lane zero gates every register except the pin data register.
	assign wrLane0 = wrTake & avs_byteenable[0];
	assign rdTake = access & avs_read;

	// Read words: the upper three bytes are always zero.
	assign rdPinData = {24'h0000_00, readPins};
	assign rdDirection = {24'h0000_00, pinDirection_q};
	assign rdLatch = {24'h0000_00, outLatch_q};
	assign rdAnalog = {24'h0000_00, analogSel_q};
	assign rdFunc = {24'h0000_00, 2'h0, funcEnable_q};

	// Two-cycle access: the first cycle stalls, the second answers.
	always @(posedge core_clk)
	begin
		if (sys_rst)
			ack_q <= 1'b0;
		else
			ack_q <= access;
	end

	// Three stages per pin; the second feeds the third, and both feed the filter.
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
			sync3_q <= 8'h00;
		end
		else
		begin
			sync1_q <= pinIn;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// A change counts once the second and third stages agree.
	always @(posedge core_clk)
	begin
		if (sys_rst)
			pinLevel_q <= 8'h00;
		else
			pinLevel_q <= (sync2_q & sync3_q)
				| (pinLevel_q & (sync2_q | sync3_q));
	end

	// Reset leaves every pin an input, with analog select set on pins 0 to 5.
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			pinDirection_q <= `BPP_RST_DIRECTION;
		end
		else if (wrLane0 & selDir)
		begin
			pinDirection_q <= wrByte;
		end
	end

	// A data write lands even with lane zero off, and then stores the sampled pins.
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			outLatch_q <= `BPP_RST_OUT_LATCH;
		end
		else if (wrTake & selData)
		begin
			outLatch_q <= rmwValue;
		end
		else if (wrLane0 & selLatch)
		begin
			outLatch_q <= wrByte;
		end
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			analogSel_q <= `BPP_RST_ANALOG_SEL;
		end
		else if (wrLane0 & selAna)
		begin
			analogSel_q <= wrByte & `BPP_ANALOG_MASK;
		end
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			funcEnable_q <= 6'h00;
		end
		else if (wrLane0 & selFunc)
		begin
			funcEnable_q <= wrByte[5:0];
		end
	end

	always @*
	begin
		case (avs_address)
			`BPP_OFS_PIN_DATA: readMux = rdPinData;
			`BPP_OFS_DIRECTION: readMux = rdDirection;
			`BPP_OFS_OUT_LATCH: readMux = rdLatch;
			`BPP_OFS_ANALOG_SEL: readMux = rdAnalog;
			`BPP_OFS_FUNC_ENABLE: readMux = rdFunc;
			default: readMux = 32'h0000_0000;
		endcase
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
			avs_readdata <= 32'h0000_0000;
		else if (rdTake)
			avs_readdata <= readMux;
	end

	// Digital buffer: analog-selected pins read low.
	always @(posedge core_clk)
	begin
		if (sys_rst)
			digitalIn <= 8'h00;
		else
			digitalIn <= readPins;
	end

	// Change sensing keeps running while the pin drives an output.
	always @(posedge core_clk)
	begin
		if (sys_rst)
			changeSenseIn <= 8'h00;
		else
			changeSenseIn <= readPins;
	end

	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : gPin
			wire dbg;
			wire lcd;
			wire ana;
			wire bias;
			wire ext;
			wire chg;
			reg [2:0] owner;
			reg drv;
			reg val;

			// Debug lines: pin 6 uses index zero and pin 7 index one.
			assign dbg = (i >= 6) & funcEnable_q[`BPP_FE_DEBUG]
				& debugOutEn[i % 2];
			assign lcd = funcEnable_q[`BPP_FE_LCD] & lcdOutEn[i];
			// The analog channel claims only a pin left as an input.
			assign ana = analogEnable[i] & pinDirection_q[i];
			assign bias = (i >= 1) & (i <= 3) & funcEnable_q[`BPP_FE_BIAS]
				& biasOutEn[i];
			assign ext = (i == 0) & funcEnable_q[`BPP_FE_EXTINT] & extIntOutEn;
			assign chg = funcEnable_q[`BPP_FE_CHANGE] & changeOutEn[i];

			// The highest enabled claim owns the pin.
			always @*
			begin
				if (dbg)
				begin
					owner = OWN_DEBUG;
				end
				else if (lcd)
				begin
					owner = OWN_LCD;
				end
				else if (ana)
				begin
					owner = OWN_ANALOG;
				end
				else if (bias)
				begin
					owner = OWN_BIAS;
				end
				else if (ext)
				begin
					owner = OWN_EXTINT;
				end
				else if (chg)
				begin
					owner = OWN_CHANGE;
				end
				else
				begin
					owner = OWN_LATCH;
				end
			end

			// The owner decides driver enable and level.
			always @*
			begin
				case (owner)
					OWN_DEBUG:
					begin
						drv = 1'b1;
						val = debugOutVal[i % 2];
					end
					OWN_LCD:
					begin
						drv = 1'b1;
						val = lcdOutVal[i];
					end
					OWN_ANALOG:
					begin
						drv = 1'b0;
						val = 1'b0;
					end
					OWN_BIAS:
					begin
						drv = 1'b1;
						val = biasOutVal[i];
					end
					OWN_EXTINT:
					begin
						drv = 1'b1;
						val = extIntOutVal;
					end
					OWN_CHANGE:
					begin
						drv = 1'b1;
						val = changeOutVal[i];
					end
					OWN_LATCH:
					begin
						drv = ~pinDirection_q[i];
						val = outLatch_q[i];
					end
					default:
					begin
						drv = 1'b0;
						val = 1'b0;
					end
				endcase
			end
			assign pinOe[i] = drv;
			assign pinOut[i] = val & drv;
		end
	endgenerate
endmodule // bpp_port

// ===== test/bpp_monitor.sv
// Checker of bus timing, pin drive and analog masking.
`timescale 1ns/1ps
module bpp_monitor
(
	input core_clk, // In.
	input sys_rst, // In.
	input [3:0] avs_address, // In.
	input avs_read, // In.
	input avs_write, // In.
	input [31:0] avs_writedata, // In.
	input [3:0] avs_byteenable, // In.
	input avs_waitrequest, // In.
	input [31:0] avs_readdata, // In.
	input [7:0] pinOut, // In.
	input [7:0] pinOe, // In.
	input [7:0] digitalIn, // In.
	input [7:0] analogEnable // In.
);
	reg [7:0] dir_q;
	reg [7:0] ana_q;
	reg [7:0] fe_q;
	wire wrOk = avs_write && !avs_waitrequest && avs_byteenable[0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			dir_q <= 8'hFF;
			ana_q <= 8'h3F;
			fe_q <= 8'h00;
		end
		else if (wrOk)
		begin
			if (avs_address == 4'h1)
				dir_q <= avs_writedata[7:0];
			if (avs_address == 4'h3)
				ana_q <= avs_writedata[7:0] & 8'h3F;
			if (avs_address == 4'h4)
				fe_q <= avs_writedata[7:0];
		end
	end
	AST_RD: assert property ($rose(avs_read)
		|-> avs_waitrequest ##1 !avs_waitrequest) else $error("read wait");
	AST_WR: assert property ($rose(avs_write)
		|-> avs_waitrequest ##1 !avs_waitrequest) else $error("write wait");
	AST_RST: assert property ($fell(sys_rst) |-> pinOe == 8'h00)
		else $error("reset drive");
	AST_DIR: assert property (fe_q == 8'h00 |-> pinOe == ~dir_q)
		else $error("direction");
	AST_OFF: assert property ((pinOut & ~pinOe) == 8'h00)
		else $error("undriven level");
	AST_DIN: assert property ((digitalIn & $past(ana_q)) == 8'h00)
		else $error("analog read");
	AST_AEN: assert property (analogEnable == (ana_q & {8{fe_q[2]}}))
		else $error("analog enable");
	AST_ARD: assert property (avs_read && !avs_waitrequest
		&& avs_address == 4'h3 |-> avs_readdata[7:0] == ana_q)
		else $error("analog register");
endmodule // bpp_monitor
bind bpp_port bpp_monitor i_mon (.*);

// ===== test/bpp_pads.sv
// Pad model: each pin shows the block's drive or the outside level.
`timescale 1ns/1ps
module bpp_pads
(
	input [7:0] pinOut, // Block level.
	input [7:0] pinOe, // Block drive.
	input [7:0] extLevel, // Outside level.
	output [7:0] pinIn // Pad level.
);
	assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule // bpp_pads

// ===== test/bpp_port_tb.sv
// Bench driving the port registers and pads.
`timescale 1ns/1ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin failures++; \
$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module bpp_port_tb;
	logic core_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
	logic extIntOutEn = 0, extIntOutVal = 0;
	logic [1:0] debugOutEn = '0, debugOutVal = '0;
	logic [3:0] avs_address = '0, avs_byteenable = '0;
	logic [31:0] avs_writedata = '0;
	logic [7:0] extLevel = '0, lcdOutEn = '0, lcdOutVal = '0, rdq;
	logic [7:0] biasOutEn = '0, biasOutVal = '0;
	logic [7:0] changeOutEn = '0, changeOutVal = '0;
	wire avs_waitrequest;
	wire [31:0] avs_readdata;
	wire [7:0] pinIn, pinOut, pinOe, digitalIn, analogEnable;
	int failures = 0, nTests = 0;
	bpp_port i_dut (.*, .changeSenseIn());
	bpp_pads i_pads (.*);
	initial
	begin
		forever #5 core_clk = ~core_clk;
	end
	task summarize;
		$display("tests %0d failures %0d", nTests, failures);
		if (failures == 0 && nTests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task acc(input bit w, input [3:0] a, input [7:0] d, input [3:0] be);
		int i;
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		for (i = 0; i < 20; i++)
		begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rdq = avs_readdata[7:0];
		avs_read <= 0;
		avs_write <= 0;
		@(posedge core_clk);
		if (i == 20)
		begin
			failures++;
			summarize;
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		acc(1'b1, a, d, 4'h1);
	endtask
	task rd(input [3:0] a, input [7:0] e);
		acc(1'b0, a, 8'h00, 4'h1);
		`CHK(rdq, e)
	endtask
	initial
	begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 0;
		rd(4'h1, 8'hFF);
		rd(4'h2, 8'h00);
		rd(4'h7, 8'h00);
		wr(4'h3, 8'hFF);
		rd(4'h3, 8'h3F);
		$display("end reset");
		wr(4'h1, 8'h0F);
		wr(4'h2, 8'hA5);
		extLevel <= 8'h53;
		repeat (6) @(posedge core_clk);
		`CHK({pinOe, pinOut}, 16'hF0A0)
		rd(4'h0, 8'h80);
		wr(4'h3, 8'h00);
		repeat (6) @(posedge core_clk);
		rd(4'h0, 8'hA3);
		acc(1'b1, 4'h0, 8'h00, 4'h0);
		rd(4'h2, 8'hA3);
		$display("end pins");
		debugOutEn <= 2'b11;
		debugOutVal <= 2'b10;
		lcdOutEn <= 8'h30;
		lcdOutVal <= 8'h10;
		biasOutEn <= 8'h0E;
		biasOutVal <= 8'h04;
		extIntOutEn <= 1;
		extIntOutVal <= 1;
		changeOutEn <= 8'hFF;
		wr(4'h4, 8'h3F);
		`CHK({pinOe, pinOut}, 16'hFF95)
		wr(4'h4, 8'h3E);
		`CHK({pinOe, pinOut}, 16'hFF15)
		wr(4'h3, 8'h3F);
		`CHK(analogEnable, 8'h3F)
		`CHK({pinOe, pinOut}, 16'hF010)
		$display("end priority");
		summarize;
	end
endmodule // bpp_port_tb
